// ---- dv/hpcp_user_model.sv ----
// User fabric model: plays queued requests onto the request port, one per cycle.
// Assumes the bench pushes entries and that rd_ready is the design's acceptance level.
`timescale 1ns/1ps
module hpcp_user_model
    import hpcp_pkg::*;
(
    input  wire logic   core_clk,
    input  wire logic   sys_rst,
    input  wire logic   rd_ready,
    output hpcp_req_type req
);
    hpcp_req_type q[$];
    hpcp_req_type nxt;
    logic         rdy;

    task automatic push(input hpcp_req_type r);
        q.push_back(r);
    endtask

    // Readiness is taken where it has settled, half a cycle before the edge that uses it.
    always @(negedge core_clk) begin
        rdy = rd_ready;
    end

    // The choice is made on the edge, so an entry pushed just after the previous edge is never raced.
    always @(posedge core_clk) begin
        if (sys_rst) begin
            nxt = '0;
        end else if (req.valid && !rdy) begin
            // A refused request is held until the block is awake again.
            nxt = req;
        end else if (q.size() > 0) begin
            nxt = q.pop_front();
        end else begin
            // Released lines flip so a stale value is never mistaken for a live one.
            nxt = {1'b0, ~req[2:0]};
        end
        #1;
        req = nxt;
    end
endmodule

// ---- dv/test_hpcp_policy.sv ----
// Self-checking bench for the command-policy block, with a cycle model of the command output.
// Assumes a 40 MHz core clock and a synchronous active-high reset.
`timescale 1ns/1ps
module test_hpcp_policy;
    import hpcp_pkg::*;
    logic core_clk = 1'b0, sys_rst = 1'b1, ext_ref_valid = 1'b0, ext_ref_all = 1'b0;
    logic rd_err_single = 1'b0, rd_err_double = 1'b0, rd_ready, ref_all, ref_bank_valid, pdown;
    logic width_288, ecc_gen, ecc_corrected, ecc_uncorrectable, pv, pap, pw;
    logic [3:0] ext_ref_bank = 4'h0, ref_bank, pbl, b;
    logic [STRB_W-1:0] wr_strb = '0, dram_mask;
    hpcp_cfg_type cfg = '0;
    hpcp_req_type req, r;
    hpcp_cmd_type cmd;
    int fails = 0, n_checks = 0, n;

    always #12.5 core_clk = ~core_clk;

    hpcp_policy dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .cfg(cfg), .req(req),
        .ext_ref_valid(ext_ref_valid), .ext_ref_all(ext_ref_all), .ext_ref_bank(ext_ref_bank),
        .wr_strb(wr_strb), .rd_err_single(rd_err_single), .rd_err_double(rd_err_double),
        .rd_ready(rd_ready), .cmd(cmd), .ref_all(ref_all), .ref_bank_valid(ref_bank_valid),
        .ref_bank(ref_bank), .pdown(pdown), .width_288(width_288), .ecc_gen(ecc_gen),
        .ecc_corrected(ecc_corrected), .ecc_uncorrectable(ecc_uncorrectable), .dram_mask(dram_mask));
    hpcp_user_model user_u (.core_clk(core_clk), .sys_rst(sys_rst), .rd_ready(rd_ready), .req(req));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_win(input string nm, input int e, input int g);
        n_checks++;
        if (g < e - 3 || g > e + 3) begin
            fails++;
            $display("wrong value %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic step();
        @(posedge core_clk);
        #1;
    endtask

    task automatic summarize();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Bounded wait on ref_all (w=0) or pdown (w=1); n counts the cycles taken.
    task automatic wait_for(input int w, output int n);
        n = 0;
        do begin
            step();
            n++;
        end while (!(w != 0 ? pdown : ref_all) && n < 900);
        if (n >= 900) begin
            fails++;
            summarize();
        end
    endtask

    task automatic meas(input hpcp_ref_policy_type p, input int e);
        cfg.ref_policy = p;
        wait_for(0, n);
        wait_for(0, n);
        chk_win("refresh_gap", e, n);
    endtask

    // Command model: what each accepted request must turn into one edge later.
    // Sampled on the falling edge, where both the request and the command have settled.
    always @(negedge core_clk) begin
        if (!sys_rst) begin
            chk("cmd_valid", {31'h0, pv}, {31'h0, cmd.valid});
            if (pv) chk("cmd_write", {31'h0, pw}, {31'h0, cmd.is_write});
            if (pv) chk("cmd_ap", {31'h0, pap}, {31'h0, cmd.auto_pre});
            if (pv) chk("cmd_bl", {28'h0, pbl}, {28'h0, cmd.burst_len});
        end
        pv = !sys_rst && req.valid && rd_ready;
        pw = req.is_write;
        pap = req.ap_req && ((req.is_write ? cfg.wr_ap_obey : cfg.rd_ap_obey) || !req.row_hit_next);
        pbl = cfg.bl8_en ? 4'h8 : 4'h4;
    end

    initial begin
        void'($urandom(32'h60c6));
        repeat (20) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        chk("rd_ready", 1, rd_ready);
        chk("pdown", 0, pdown);
        for (int i = 0; i < 64; i++) begin
            cfg.rd_ap_obey = i[0];
            cfg.wr_ap_obey = i[1];
            cfg.bl8_en = i[2];
            r = hpcp_req_type'(4'($urandom) | {~i[5], 3'h0});
            user_u.push(r);
            step();
        end
        repeat (3) step();
        for (int i = 0; i < 8; i++) begin
            cfg.ecc_en = i[0];
            cfg.write_byte_mask_en = i[1];
            cfg.wide_data = i[2];
            wr_strb = $urandom;
            user_u.push(4'hc);
            repeat (2) step();
            chk("width_288", {31'h0, i[2] & ~i[0] & ~i[1]}, {31'h0, width_288});
            chk("ecc_gen", {31'h0, i[0]}, {31'h0, ecc_gen});
            chk("dram_mask", (i[1] && !i[0]) ? ~wr_strb : '0, dram_mask);
        end
        cfg.ecc_en = 1'b1;
        rd_err_single = 1'b1;
        step();
        rd_err_single = 1'b0;
        rd_err_double = 1'b1;
        chk("ecc_corrected", 1, ecc_corrected);
        chk("ecc_uncorrectable", 0, ecc_uncorrectable);
        step();
        rd_err_double = 1'b0;
        chk("ecc_uncorrectable", 1, ecc_uncorrectable);
        chk("ecc_corrected", 0, ecc_corrected);
        cfg = '0;
        rd_err_single = 1'b1;
        step();
        rd_err_single = 1'b0;
        chk("ecc_corrected", 0, ecc_corrected);
        cfg.ext_refresh = 1'b1;
        for (int i = 0; i < 18; i++) begin
            cfg.ext_refresh = (i < 17);
            ext_ref_valid = 1'b1;
            ext_ref_all = (i == 0);
            ext_ref_bank = 4'($urandom);
            b = ext_ref_bank;
            step();
            ext_ref_valid = 1'b0;
            chk("ref_all", {31'h0, i == 0}, {31'h0, ref_all});
            chk("ref_bank_valid", {31'h0, i > 0 && i < 17}, {31'h0, ref_bank_valid});
            if (i > 0 && i < 17) chk("ref_bank", {28'h0, b}, {28'h0, ref_bank});
        end
        cfg.ext_refresh = 1'b1;
        cfg.pd_en = 1'b1;
        user_u.push(4'h8);
        step();
        wait_for(1, n);
        chk_win("pdown_delay", PD_IDLE_CYC, n);
        user_u.push(4'h9);
        repeat (4) step();
        chk("pdown", 0, pdown);
        chk("rd_ready", 1, rd_ready);
        cfg = '0;
        meas(HPCP_REF_FLEX, REF_INT_CYC);
        meas(HPCP_REF_EARLY, REF_EARLY_CYC);
        meas(HPCP_REF_LATE, REF_INT_CYC);
        for (int i = 0; i < 800; i++) user_u.push(hpcp_req_type'(4'($urandom) | 4'h8));
        meas(HPCP_REF_LATE, REF_LATE_CYC);
        summarize();
    end
endmodule

// ---- hw/hpcp_pkg.sv ----
// Package for the pseudo-channel command-policy block: modes, timing constants and carrier structs.
// Assumes a single 40 MHz core clock shared by every user of these definitions.
package hpcp_pkg;

    localparam int          CLK_MHZ          = 40;
    // Power-down entry idle time in ns, and the refresh interval in ns.
    localparam int          PD_IDLE_NS       = 2000;
    localparam int          PD_IDLE_CYC      = (PD_IDLE_NS * CLK_MHZ) / 1000;
    localparam int          REF_INT_NS       = 3900;
    localparam int          REF_INT_CYC      = (REF_INT_NS * CLK_MHZ) / 1000;
    localparam int          REF_EARLY_CYC    = REF_INT_CYC / 2;
    localparam int          REF_LATE_CYC     = REF_INT_CYC * 2;
    localparam int          CNT_W            = 12;
    localparam int          BANKS            = 16;
    localparam int          DATA_W           = 256;
    localparam int          WIDE_W           = 288;
    localparam int          STRB_W           = DATA_W / 8;
    localparam logic [3:0]  BL_32B           = 4'h4;
    localparam logic [3:0]  BL_64B           = 4'h8;
    localparam logic [CNT_W-1:0] CNT_ZERO    = 12'h000;
    localparam logic [CNT_W-1:0] CNT_ONE     = 12'h001;

    typedef enum logic [1:0] {
        HPCP_REF_FLEX  = 2'h0,
        HPCP_REF_EARLY = 2'h1,
        HPCP_REF_LATE  = 2'h2
    } hpcp_ref_policy_type;

    // Power state, one-hot.
    typedef enum logic [1:0] {
        HPCP_ST_ACTIVE = 2'b01,
        HPCP_ST_PDOWN  = 2'b10
    } hpcp_state_type;

    typedef struct packed {
        logic                rd_ap_obey;     // read_precharge_obey_mode when 1, advisory when 0
        logic                wr_ap_obey;     // write_precharge_obey_mode when 1, advisory when 0
        logic                pd_en;
        logic                ext_refresh;
        hpcp_ref_policy_type ref_policy;
        logic                bl8_en;
        logic                wide_data;
        logic                ecc_en;
        logic                write_byte_mask_en;
    } hpcp_cfg_type;

    typedef struct packed {
        logic                valid;
        logic                is_write;
        logic                ap_req;       // aruser/awuser precharge bit
        logic                row_hit_next; // next queued access hits the same row
    } hpcp_req_type;

    typedef struct packed {
        logic                valid;
        logic                is_write;
        logic                auto_pre;
        logic [3:0]          burst_len;
    } hpcp_cmd_type;

endpackage

// ---- hw/hpcp_policy.sv ----
// Command-policy core for one pseudo channel: precharge, power-down, refresh, burst and data-path options.
// Assumes requests, config and external refresh strobes are synchronous to core_clk.
`timescale 1ns/1ps

// Overview of operation
// (R1) Read precharge bit is obeyed in obey mode, weighed against row locality otherwise.
// (R2) Write precharge bit is obeyed in obey mode, weighed against row locality otherwise.
// (R3) With power-down enabled, enter power-down after queue stays empty long enough.
// (R4) In controller refresh mode, all-bank refreshes come only from the internal timer.
// (R5) In external refresh mode, sideband requests for all or single banks are issued.
// (R6) Flexible policy issues refresh on the controller's own interval timer.
// (R7) Early policy issues refresh from half the interval on whenever the queue is idle.
// (R8) Late policy holds refresh until idle or until it can wait no longer.
// (R9) Burst length 8 with 64-byte access, otherwise burst length 4.
// (R10) Data width is 256 bits; 288 only without ECC and byte mask.
// (R11) ECC generates check bits on writes, corrects single and flags double errors.
// (R12) Byte masking is never applied while ECC is enabled.
// (R13) With byte mask enabled, DRAM mask bits follow the write strobes.
// (R14) A new request ends power-down at once and command issue resumes.
module hpcp_policy (
    input  wire logic                 core_clk,
    input  wire logic                 sys_rst,
    input  wire hpcp_pkg::hpcp_cfg_type cfg,
    input  wire hpcp_pkg::hpcp_req_type req,
    input  wire logic                 ext_ref_valid,
    input  wire logic                 ext_ref_all,
    input  wire logic [3:0]           ext_ref_bank,
    input  wire logic [hpcp_pkg::STRB_W-1:0] wr_strb,
    input  wire logic                 rd_err_single,
    input  wire logic                 rd_err_double,
    output logic                      rd_ready,
    output hpcp_pkg::hpcp_cmd_type    cmd,
    output logic                      ref_all,
    output logic                      ref_bank_valid,
    output logic [3:0]                ref_bank,
    output logic                      pdown,
    output logic                      width_288,
    output logic                      ecc_gen,
    output logic                      ecc_corrected,
    output logic                      ecc_uncorrectable,
    output logic [hpcp_pkg::STRB_W-1:0] dram_mask
);
    import hpcp_pkg::*;

    hpcp_state_type   state_reg,  state_next;
    logic [CNT_W-1:0] idle_reg,   idle_next;
    logic [CNT_W-1:0] ref_reg,    ref_next;
    hpcp_cmd_type     cmd_reg,    cmd_next;
    logic             rall_reg,   rall_next;
    logic             rbv_reg,    rbv_next;
    logic [3:0]       rbank_reg,  rbank_next;
    logic             w288_reg,   w288_next;
    logic             eg_reg,     eg_next;
    logic             ec_reg,     ec_next;
    logic             eu_reg,     eu_next;
    logic [STRB_W-1:0] mask_reg,  mask_next;
    logic             pd_reg,     pd_next;
    logic             rdy_reg,    rdy_next;
    logic             ref_due;
    logic             ref_fire;
    logic             ap_dec;

    always_comb begin
        // Refresh point depends on policy; the late policy still caps the wait at twice the interval.
        case (cfg.ref_policy)
            HPCP_REF_EARLY: ref_due = (ref_reg >= CNT_W'(REF_INT_CYC))
                                      || ((ref_reg >= CNT_W'(REF_EARLY_CYC)) && !req.valid); // R7
            HPCP_REF_LATE:  ref_due = ((ref_reg >= CNT_W'(REF_INT_CYC)) && !req.valid)
                                      || (ref_reg >= CNT_W'(REF_LATE_CYC)); // R8
            default:        ref_due = (ref_reg >= CNT_W'(REF_INT_CYC)); // R6
        endcase
        ref_fire = !cfg.ext_refresh && ref_due; // R4
        // Advisory mode keeps the row open when the next access hits it.
        if (req.is_write) begin
            ap_dec = cfg.wr_ap_obey ? req.ap_req : (req.ap_req && !req.row_hit_next); // R2
        end else begin
            ap_dec = cfg.rd_ap_obey ? req.ap_req : (req.ap_req && !req.row_hit_next); // R1
        end
    end

    always_comb begin
        state_next = state_reg;
        idle_next  = req.valid ? CNT_ZERO : ((idle_reg == {CNT_W{1'b1}}) ? idle_reg : idle_reg + CNT_ONE);
        case (state_reg)
            HPCP_ST_ACTIVE: begin
                if (cfg.pd_en && !req.valid && (idle_reg >= CNT_W'(PD_IDLE_CYC - 1))) begin
                    state_next = HPCP_ST_PDOWN; // R3
                end
            end
            HPCP_ST_PDOWN: begin
                if (req.valid || !cfg.pd_en || ref_fire) begin
                    state_next = HPCP_ST_ACTIVE; // R14
                end
            end
            default: state_next = HPCP_ST_ACTIVE;
        endcase
        // Both status outputs are registered from the next state, so neither passes through a decoder.
        pd_next    = (state_next == HPCP_ST_PDOWN); // R3
        rdy_next   = (state_next == HPCP_ST_ACTIVE); // R14
        ref_next   = ref_fire ? CNT_ZERO : ((ref_reg == {CNT_W{1'b1}}) ? ref_reg : ref_reg + CNT_ONE);
        rall_next  = ref_fire || (cfg.ext_refresh && ext_ref_valid && ext_ref_all); // R5
        rbv_next   = cfg.ext_refresh && ext_ref_valid && !ext_ref_all; // R5
        rbank_next = ext_ref_valid ? ext_ref_bank : rbank_reg;
        cmd_next.valid     = req.valid && (state_reg == HPCP_ST_ACTIVE);
        cmd_next.is_write  = req.is_write;
        cmd_next.auto_pre  = req.valid && ap_dec;
        cmd_next.burst_len = cfg.bl8_en ? BL_64B : BL_32B; // R9
        w288_next  = cfg.wide_data && !cfg.ecc_en && !cfg.write_byte_mask_en; // R10
        eg_next    = cfg.ecc_en && req.valid && req.is_write; // R11
        ec_next    = cfg.ecc_en && rd_err_single && !rd_err_double; // R11
        eu_next    = cfg.ecc_en && rd_err_double; // R11
        // Mask bit high means the byte is not written; ECC forbids masking.
        mask_next  = (cfg.write_byte_mask_en && !cfg.ecc_en) ? ~wr_strb : '0; // R12 R13
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= HPCP_ST_ACTIVE;
            idle_reg  <= CNT_ZERO;
            ref_reg   <= CNT_ZERO;
            cmd_reg   <= '0;
            rall_reg  <= 1'b0;
            rbv_reg   <= 1'b0;
            rbank_reg <= 4'h0;
            w288_reg  <= 1'b0;
            eg_reg    <= 1'b0;
            ec_reg    <= 1'b0;
            eu_reg    <= 1'b0;
            mask_reg  <= '0;
            pd_reg    <= 1'b0;
            rdy_reg   <= 1'b1;
        end else begin
            state_reg <= state_next;
            idle_reg  <= idle_next;
            ref_reg   <= ref_next;
            cmd_reg   <= cmd_next;
            rall_reg  <= rall_next;
            rbv_reg   <= rbv_next;
            rbank_reg <= rbank_next;
            w288_reg  <= w288_next;
            eg_reg    <= eg_next;
            ec_reg    <= ec_next;
            eu_reg    <= eu_next;
            mask_reg  <= mask_next;
            pd_reg    <= pd_next;
            rdy_reg   <= rdy_next;
        end
    end

    assign rd_ready          = rdy_reg;
    assign cmd               = cmd_reg;
    assign ref_all           = rall_reg;
    assign ref_bank_valid    = rbv_reg;
    assign ref_bank          = rbank_reg;
    assign pdown             = pd_reg;
    assign width_288         = w288_reg;
    assign ecc_gen           = eg_reg;
    assign ecc_corrected     = ec_reg;
    assign ecc_uncorrectable = eu_reg;
    assign dram_mask         = mask_reg;

    chk_pd_entry: assert property (@(posedge core_clk) disable iff (sys_rst) // R3
        (state_reg == HPCP_ST_ACTIVE && cfg.pd_en && !req.valid && idle_reg >= CNT_W'(PD_IDLE_CYC - 1))
        |=> pdown) else $error("power-down not entered after idle time");
    chk_pd_exit: assert property (@(posedge core_clk) disable iff (sys_rst) // R14
        (pdown && req.valid) |=> !pdown) else $error("power-down not left on request");
    chk_no_pd_off: assert property (@(posedge core_clk) disable iff (sys_rst) // R3
        (!cfg.pd_en && $stable(cfg.pd_en)) |=> !pdown) else $error("power-down while disabled");
    chk_ref_internal: assert property (@(posedge core_clk) disable iff (sys_rst) // R4
        (cfg.ext_refresh && $past(cfg.ext_refresh) && !$past(ext_ref_valid)) |-> !ref_all)
        else $error("internal refresh in external mode");
    chk_ref_ext_bank: assert property (@(posedge core_clk) disable iff (sys_rst) // R5
        (cfg.ext_refresh && ext_ref_valid && !ext_ref_all) |=> (ref_bank_valid && ref_bank == $past(ext_ref_bank)))
        else $error("bank refresh request dropped");
    chk_ref_flex: assert property (@(posedge core_clk) disable iff (sys_rst) // R6
        (!cfg.ext_refresh && cfg.ref_policy == HPCP_REF_FLEX && ref_reg == CNT_W'(REF_INT_CYC)) |=> ref_all)
        else $error("flexible refresh missed");
    chk_ref_late_cap: assert property (@(posedge core_clk) disable iff (sys_rst) // R8
        (!cfg.ext_refresh && cfg.ref_policy == HPCP_REF_LATE && ref_reg < CNT_W'(REF_INT_CYC)) |=> !ref_all)
        else $error("late refresh issued too soon");
    chk_burst_len: assert property (@(posedge core_clk) disable iff (sys_rst) // R9
        cmd.valid |-> (cmd.burst_len == ($past(cfg.bl8_en) ? BL_64B : BL_32B))) else $error("wrong burst length");
    chk_ap_obey: assert property (@(posedge core_clk) disable iff (sys_rst) // R1
        (req.valid && !req.is_write && cfg.rd_ap_obey) |=> (cmd.auto_pre == $past(req.ap_req)))
        else $error("read precharge not obeyed");
    chk_mask_ecc: assert property (@(posedge core_clk) disable iff (sys_rst) // R12
        $past(cfg.ecc_en) |-> (dram_mask == '0)) else $error("mask applied with ecc");
    chk_w288: assert property (@(posedge core_clk) disable iff (sys_rst) // R10
        width_288 |-> !$past(cfg.ecc_en) && !$past(cfg.write_byte_mask_en)) else $error("288 bits with ecc or mask");

    // A request seen in power-down wakes the block but is not issued in that cycle.
    chk_pd_refuse: assert property (@(posedge core_clk) disable iff (sys_rst) // R14
        (pdown && req.valid) |=> (rd_ready && !cmd.valid))
        else $error("refused request issued or block not awake");
    chk_ap_obey_wr: assert property (@(posedge core_clk) disable iff (sys_rst) // R2
        (req.valid && req.is_write && cfg.wr_ap_obey) |=> (cmd.auto_pre == $past(req.ap_req)))
        else $error("write precharge not obeyed");
    chk_ap_keep_open: assert property (@(posedge core_clk) disable iff (sys_rst) // R1
        (req.valid && !req.is_write && !cfg.rd_ap_obey && req.row_hit_next) |=> !cmd.auto_pre)
        else $error("row closed although next access hits it");
    chk_ref_ext_all: assert property (@(posedge core_clk) disable iff (sys_rst) // R5
        (cfg.ext_refresh && ext_ref_valid && ext_ref_all) |=> (ref_all && !ref_bank_valid))
        else $error("all-bank refresh request dropped");
    chk_ref_early: assert property (@(posedge core_clk) disable iff (sys_rst) // R7
        (!cfg.ext_refresh && cfg.ref_policy == HPCP_REF_EARLY && !req.valid
         && ref_reg == CNT_W'(REF_EARLY_CYC)) |=> ref_all)
        else $error("early refresh not taken while idle");
    chk_ref_late_max: assert property (@(posedge core_clk) disable iff (sys_rst) // R8
        (!cfg.ext_refresh && cfg.ref_policy == HPCP_REF_LATE && ref_reg == CNT_W'(REF_LATE_CYC)) |=> ref_all)
        else $error("late refresh delayed past its limit");
    chk_ecc_double: assert property (@(posedge core_clk) disable iff (sys_rst) // R11
        (cfg.ecc_en && rd_err_double) |=> (ecc_uncorrectable && !ecc_corrected))
        else $error("double-bit error not flagged");
    chk_mask_strb: assert property (@(posedge core_clk) disable iff (sys_rst) // R13
        (cfg.write_byte_mask_en && !cfg.ecc_en) |=> (dram_mask == ~$past(wr_strb)))
        else $error("write mask does not follow strobes");

    cov_pd_cycle: cover property (@(posedge core_clk) disable iff (sys_rst) pdown ##1 !pdown);
    cov_ref_all:  cover property (@(posedge core_clk) disable iff (sys_rst) ref_all);
    cov_ref_bank: cover property (@(posedge core_clk) disable iff (sys_rst) ref_bank_valid);
    cov_ap_write: cover property (@(posedge core_clk) disable iff (sys_rst) cmd.valid && cmd.is_write && cmd.auto_pre);
    cov_pd_wake:  cover property (@(posedge core_clk) disable iff (sys_rst) pdown && req.valid);

endmodule
